// ==== hw/ccc_pkg.sv ====
// constants and types for the converter configuration and calibration block
// assumes a single pclk domain; registers are reached over apb
`default_nettype none
package ccc_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_SETUP = 8'h00;
	localparam logic [7:0] IDX_MUX   = 8'h01;
	localparam logic [7:0] IDX_ACR   = 8'h02;
	localparam logic [7:0] IDX_CURRENT_SOURCE_ONE = 8'h03;
	localparam logic [7:0] IDX_CURRENT_SOURCE_TWO = 8'h04;
	localparam logic [7:0] IDX_OFFSET_TRIM_CODE  = 8'h05;
	localparam logic [7:0] IDX_MDEC1 = 8'h09;
	localparam logic [7:0] IDX_CMD   = 8'h10;
	localparam logic [7:0] IDX_STAT  = 8'h11;
	localparam logic [7:0] IDX_DATA  = 8'h12;
	localparam int ADDR_W = 10;
	// field positions
	localparam int SETUP_ID     = 5;
	localparam int SETUP_SPEED  = 4;
	localparam int SETUP_REF_EN = 3;
	localparam int SETUP_REFERENCE_LEVEL_SELECT = 2;
	localparam int SETUP_BUF_EN = 1;
	localparam int MUX_POS      = 4;
	localparam int ACR_BOCS     = 7;
	localparam int ACR_RANGE2   = 5;
	localparam int ACR_RANGE1   = 3;
	localparam int OFFSET_TRIM_CODE_SIGN    = 7;
	localparam int MDEC1_RDY    = 7;
	localparam int MDEC1_SMODE  = 3;
	// reset values
	localparam logic [7:0] RST_SETUP = 8'h00;
	localparam logic [7:0] RST_MUX   = 8'h01;
	localparam logic [7:0] RST_ZERO  = 8'h00;
	localparam logic [7:0] MUX_DIODE = 8'hFF;
	// commands
	localparam logic [7:0] CMD_SELF_OFS  = 8'h01;
	localparam logic [7:0] CMD_SELF_GAIN = 8'h02;
	localparam logic [7:0] CMD_SELF_BOTH = 8'h03;
	localparam logic [7:0] CMD_SYS_OFS   = 8'h04;
	localparam logic [7:0] CMD_SYS_GAIN  = 8'h05;
	localparam logic [3:0] CAL_SINGLE = 4'h7;
	localparam logic [3:0] CAL_DOUBLE = 4'hE;
	// modulator division
	localparam int MOD_DIV_FAST = 128;
	localparam int MOD_DIV_SLOW = 256;
	localparam logic [7:0] HALF_FAST = 8'(MOD_DIV_FAST / 2 - 1);
	localparam logic [7:0] HALF_SLOW = 8'(MOD_DIV_SLOW / 2 - 1);
	// filter modes
	localparam logic [1:0] SMODE_AUTO = 2'h0;
	typedef enum logic [1:0] {
		FLT_FAST  = 2'h1,
		FLT_SINC2 = 2'h2,
		FLT_SINC3 = 2'h3
	} ccc_filt_e;
	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_CAL = 2'b10
	} ccc_state_e;
endpackage : ccc_pkg
`default_nettype wire

// ==== hw/ccc_core.sv ====
// register file, input routing, modulator divider and calibration sequencer
// assumes an apb master on pclk and an asynchronous buffer-enable pin
//
// The placing of the registers and register access over APB were left to the implementer.
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Function
// - any input may be positive side, any other the negative side
// - selection all ones routes temperature diode, opens channels, biases it
// - burnout bit sources current on positive, sinks on negative input
// - input buffer enabled only when pin and control bit both set
// - two current outputs, each with code register and range field
// - current output off at range zero except source one in diode mode, else scaled by two to the range minus one
// - gain field decodes to power of two from one to maximum
// - offset trim is sign and seven bit magnitude
// - modulator clock is oscillator divided by 128, or 256 when speed set
// - reference on from enable bit, level from reference-high bit
// - self calibrations take seven data periods, combined fourteen
// - host applies zero or full scale; system calibration seven periods
// - ready output falls when any calibration finishes
// - filter mode fast, sinc2, sinc3 or automatic
// - automatic mode steps fast, sinc2, sinc3 after channel or gain change
// - ready falls on new result, rises once data register is read
module ccc_core #(
	parameter int DECIM   = 16,
	parameter logic [2:0] DEV_ID = 3'h5 // arbitrary value
) (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [ccc_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic                     buffer_pin,
	output logic      [7:0]               chan_pos_en,
	output logic      [7:0]               chan_neg_en,
	output logic                          diode_route,
	output logic      [7:0]               burnout_src,
	output logic      [7:0]               burnout_sink,
	output logic                          buf_active,
	output logic      [7:0]               current_source_one,
	output logic      [7:0]               current_source_two,
	output logic      [2:0]               current_source_one_scale,
	output logic      [2:0]               current_source_two_scale,
	output logic      [7:0]               gain_sel,
	output logic                          offset_sign,
	output logic      [6:0]               offset_mag,
	output logic                          modulator_clock,
	output logic                          ref_on,
	output logic                          reference_level_select,
	output logic      [1:0]               filter_active,
	output logic                          cal_active,
	output logic                          result_ready_n
);
	import ccc_pkg::*;

	function automatic logic [2:0] range_scale(input logic [1:0] r);
		range_scale = (r == 2'h0) ? 3'h0 : 3'(3'h1 << (r - 2'h1));
	endfunction

	function automatic logic [7:0] one_hot8(input logic [2:0] n);
		one_hot8 = 8'(8'h01 << n);
	endfunction

	//////////////////////////////////////////////////////////////////////////
	logic [7:0] setup_ff, nxt_setup, mux_ff, nxt_mux, acr_ff, nxt_acr;
	logic [7:0] current_source_one_ff, nxt_current_source_one, current_source_two_ff, nxt_current_source_two, offset_trim_code_ff, nxt_offset_trim_code;
	logic [1:0] smode_ff, nxt_smode;
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
	logic [7:0] div_ff, nxt_div;
	logic mclk_ff, nxt_mclk, spd_chg_ff, nxt_spd_chg;
	logic [15:0] dec_ff, nxt_dec;
	logic [3:0] cal_ff, nxt_cal;
	ccc_state_e st_ff, nxt_st;
	ccc_filt_e flt_ff, nxt_flt;
	logic rdy_n_ff, nxt_rdy_n;
	logic [15:0] res_ff, nxt_res;
	logic buf_s1_ff, buf_s2_ff;
	logic [7:0] pos_ff, neg_ff, bsrc_ff, bsnk_ff, gain_ff;
	logic [2:0] sc1_ff, sc2_ff;
	logic diode_ff, bufa_ff;
	logic [7:0] idx;
	logic wr, rd, mapped, tick_mod, tick_data;

	// apb decode: answer is prepared in setup and shown in the access cycle
	assign idx = paddr[ADDR_W-1:2];
	assign wr  = psel & penable & pready_ff & pwrite;
	assign rd  = psel & penable & pready_ff & ~pwrite;
	assign mapped = (idx inside {IDX_SETUP, IDX_MUX, IDX_ACR, IDX_CURRENT_SOURCE_ONE,
		IDX_CURRENT_SOURCE_TWO, IDX_OFFSET_TRIM_CODE, IDX_MDEC1, IDX_CMD, IDX_STAT, IDX_DATA})
		& (paddr[1:0] == 2'h0);
	assign tick_mod  = (div_ff == (setup_ff[SETUP_SPEED] ? HALF_SLOW
		: HALF_FAST)) & ~mclk_ff;
	assign tick_data = tick_mod & (dec_ff == 16'(DECIM - 1));

	//////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		nxt_setup = setup_ff;
		nxt_mux   = mux_ff;
		nxt_acr   = acr_ff;
		nxt_current_source_one = current_source_one_ff;
		nxt_current_source_two = current_source_two_ff;
		nxt_offset_trim_code  = offset_trim_code_ff;
		nxt_smode = smode_ff;
		nxt_st    = st_ff;
		nxt_cal   = cal_ff;
		nxt_flt   = flt_ff;
		nxt_rdy_n = rdy_n_ff;
		nxt_res   = res_ff;
		nxt_pready  = psel & ~penable;
		nxt_pslverr = psel & ~penable & ~mapped;
		nxt_prdata  = 32'h0;
		if (psel & ~penable & ~pwrite)
		begin
			unique case (idx)
				IDX_SETUP: nxt_prdata = {24'h0, DEV_ID, setup_ff[4:0]};
				IDX_MUX:   nxt_prdata = {24'h0, mux_ff};
				IDX_ACR:   nxt_prdata = {24'h0, acr_ff};
				IDX_CURRENT_SOURCE_ONE: nxt_prdata = {24'h0, current_source_one_ff};
				IDX_CURRENT_SOURCE_TWO: nxt_prdata = {24'h0, current_source_two_ff};
				IDX_OFFSET_TRIM_CODE:  nxt_prdata = {24'h0, offset_trim_code_ff};
				IDX_MDEC1: nxt_prdata = {24'h0, rdy_n_ff, 2'h0, smode_ff, 3'h0};
				IDX_STAT:  nxt_prdata = {28'h0, flt_ff, cal_ff == 4'h0,
					st_ff == ST_CAL};
				IDX_DATA:  nxt_prdata = {16'h0, res_ff};
				default:   nxt_prdata = 32'h0;
			endcase
		end
		// modulator divider and decimation count
		nxt_div  = tick_mod | (div_ff == (setup_ff[SETUP_SPEED] ? HALF_SLOW
			: HALF_FAST)) ? 8'h0 : 8'(div_ff + 8'h1);
		nxt_mclk = (div_ff == (setup_ff[SETUP_SPEED] ? HALF_SLOW : HALF_FAST))
			? ~mclk_ff : mclk_ff;
		nxt_dec  = tick_data ? 16'h0 : (tick_mod ? 16'(dec_ff + 16'h1)
			: dec_ff);
		// results and filter progression
		if (tick_data & (st_ff == ST_RUN))
		begin
			nxt_res   = 16'(res_ff + 16'h1);
			nxt_rdy_n = 1'b0;
			if (flt_ff == FLT_FAST)
				nxt_flt = FLT_SINC2;
			else
				nxt_flt = FLT_SINC3;
		end
		else if (rd & (idx == IDX_DATA))
			nxt_rdy_n = 1'b1;
		// calibration sequencer
		unique case (st_ff)
			ST_RUN:
				if (wr & (idx == IDX_CMD))
				begin
					if (pwdata[7:0] inside {CMD_SELF_OFS, CMD_SELF_GAIN,
						CMD_SELF_BOTH, CMD_SYS_OFS, CMD_SYS_GAIN})
					begin
						// refused codes must not load the period count
						nxt_cal = (pwdata[7:0] == CMD_SELF_BOTH) ? CAL_DOUBLE
							: CAL_SINGLE;
						nxt_st    = ST_CAL;
						nxt_rdy_n = 1'b1;
					end
				end
			ST_CAL:
				if (tick_data)
				begin
					nxt_cal = 4'(cal_ff - 4'h1);
					if (cal_ff == 4'h1)
					begin
						nxt_st    = ST_RUN;
						nxt_rdy_n = 1'b0;
					end
				end
		endcase
		// register writes; a real change of channel or gain restarts filter
		if (wr)
		begin
			unique case (idx)
				IDX_SETUP: nxt_setup = pwdata[7:0];
				IDX_MUX:   nxt_mux   = pwdata[7:0];
				IDX_ACR:   nxt_acr   = pwdata[7:0];
				IDX_CURRENT_SOURCE_ONE: nxt_current_source_one = pwdata[7:0];
				IDX_CURRENT_SOURCE_TWO: nxt_current_source_two = pwdata[7:0];
				IDX_OFFSET_TRIM_CODE:  nxt_offset_trim_code  = pwdata[7:0];
				IDX_MDEC1: nxt_smode = pwdata[MDEC1_SMODE +: 2];
				default:   nxt_setup = setup_ff;
			endcase
			if (((idx == IDX_MUX) & (pwdata[7:0] != mux_ff)) |
				((idx == IDX_ACR) & (pwdata[2:0] != acr_ff[2:0])))
				nxt_flt = FLT_FAST;
		end
		// fixed modes override the automatic stepping
		if (smode_ff != SMODE_AUTO)
			nxt_flt = ccc_filt_e'(smode_ff);
		// speed change since the last rise; that half period is irregular
		nxt_spd_chg = (nxt_mclk & ~mclk_ff) ? 1'b0 : (spd_chg_ff |
			(nxt_setup[SETUP_SPEED] != setup_ff[SETUP_SPEED]));
	end

	//////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			setup_ff   <= RST_SETUP;
			mux_ff     <= RST_MUX;
			acr_ff     <= RST_ZERO;
			current_source_one_ff   <= RST_ZERO;
			current_source_two_ff   <= RST_ZERO;
			offset_trim_code_ff    <= RST_ZERO;
			smode_ff   <= SMODE_AUTO;
			prdata_ff  <= 32'h0;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			div_ff     <= 8'h0;
			mclk_ff    <= 1'b0;
			spd_chg_ff <= 1'b0;
			dec_ff     <= 16'h0;
			cal_ff     <= 4'h0;
			st_ff      <= ST_RUN;
			flt_ff     <= FLT_FAST;
			rdy_n_ff   <= 1'b1;
			res_ff     <= 16'h0;
			buf_s1_ff  <= 1'b0;
			buf_s2_ff  <= 1'b0;
		end
		else
		begin
			setup_ff   <= nxt_setup;
			mux_ff     <= nxt_mux;
			acr_ff     <= nxt_acr;
			current_source_one_ff   <= nxt_current_source_one;
			current_source_two_ff   <= nxt_current_source_two;
			offset_trim_code_ff    <= nxt_offset_trim_code;
			smode_ff   <= nxt_smode;
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			div_ff     <= nxt_div;
			mclk_ff    <= nxt_mclk;
			spd_chg_ff <= nxt_spd_chg;
			dec_ff     <= nxt_dec;
			cal_ff     <= nxt_cal;
			st_ff      <= nxt_st;
			flt_ff     <= nxt_flt;
			rdy_n_ff   <= nxt_rdy_n;
			res_ff     <= nxt_res;
			buf_s1_ff  <= buffer_pin;
			buf_s2_ff  <= buf_s1_ff;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// routing outputs, registered one cycle after the settings
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pos_ff   <= 8'h0;
			neg_ff   <= 8'h0;
			bsrc_ff  <= 8'h0;
			bsnk_ff  <= 8'h0;
			diode_ff <= 1'b0;
			bufa_ff  <= 1'b0;
			sc1_ff   <= 3'h0;
			sc2_ff   <= 3'h0;
			gain_ff  <= 8'h01;
		end
		else
		begin
			diode_ff <= (mux_ff == MUX_DIODE);
			// diode mode leaves every external channel open
			pos_ff   <= (mux_ff == MUX_DIODE) ? 8'h0
				: one_hot8(mux_ff[MUX_POS +: 3]);
			neg_ff   <= (mux_ff == MUX_DIODE) ? 8'h0
				: one_hot8(mux_ff[2:0]);
			bsrc_ff  <= (acr_ff[ACR_BOCS] & (mux_ff != MUX_DIODE))
				? one_hot8(mux_ff[MUX_POS +: 3]) : 8'h0;
			bsnk_ff  <= (acr_ff[ACR_BOCS] & (mux_ff != MUX_DIODE))
				? one_hot8(mux_ff[2:0]) : 8'h0;
			bufa_ff  <= buf_s2_ff & setup_ff[SETUP_BUF_EN];
			// in diode mode the first source must bias the diode
			sc1_ff   <= ((mux_ff == MUX_DIODE) & (acr_ff[ACR_RANGE1 +: 2]
				== 2'h0)) ? 3'h1 : range_scale(acr_ff[ACR_RANGE1 +: 2]);
			sc2_ff   <= range_scale(acr_ff[ACR_RANGE2 +: 2]);
			gain_ff  <= one_hot8(acr_ff[2:0]);
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign chan_pos_en  = pos_ff;
	assign chan_neg_en  = neg_ff;
	assign diode_route  = diode_ff;
	assign burnout_src  = bsrc_ff;
	assign burnout_sink = bsnk_ff;
	assign buf_active   = bufa_ff;
	assign current_source_one = current_source_one_ff;
	assign current_source_two = current_source_two_ff;
	assign current_source_one_scale  = sc1_ff;
	assign current_source_two_scale  = sc2_ff;
	assign gain_sel     = gain_ff;
	assign offset_sign  = offset_trim_code_ff[OFFSET_TRIM_CODE_SIGN];
	assign offset_mag   = offset_trim_code_ff[6:0];
	assign modulator_clock = mclk_ff;
	assign ref_on       = setup_ff[SETUP_REF_EN];
	assign reference_level_select = setup_ff[SETUP_REFERENCE_LEVEL_SELECT];
	assign filter_active = flt_ff;
	assign cal_active   = (st_ff == ST_CAL);
	assign result_ready_n = rdy_n_ff;

	//////////////////////////////////////////////////////////////////////////
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_diode_open: assert property ((mux_ff == MUX_DIODE) |=>
		diode_route && chan_pos_en == 8'h0 && current_source_one_scale != 3'h0)
		else $error("diode mode routing wrong");
	chk_burnout_pair: assert property ((acr_ff[ACR_BOCS] &&
		mux_ff != MUX_DIODE) |=> burnout_src == chan_pos_en &&
		burnout_sink == chan_neg_en) else $error("burnout currents wrong");
	chk_buffer_and: assert property (buf_active ==
		($past(buf_s2_ff) && $past(setup_ff[SETUP_BUF_EN])))
		else $error("buffer enable not an and");
	chk_gain_hot: assert property ($changed(acr_ff[2:0]) |=>
		gain_sel == one_hot8($past(acr_ff[2:0]))) else $error("gain decode");
	chk_mod_half: assert property ($rose(modulator_clock) &&
		!setup_ff[SETUP_SPEED] |-> ##64 ($fell(modulator_clock) ||
		spd_chg_ff))
		else $error("modulator half period wrong");
	chk_cal_hold: assert property (cal_active |-> result_ready_n)
		else $error("ready low during calibration");
	chk_cal_done: assert property ($fell(cal_active) |->
		!result_ready_n) else $error("ready not low after calibration");
	chk_read_clear: assert property (rd && idx == IDX_DATA &&
		!tick_data && !cal_active |=> result_ready_n)
		else $error("ready not released by read");
	chk_auto_step: assert property (smode_ff == SMODE_AUTO &&
		tick_data && !wr && !cal_active && flt_ff == FLT_FAST |=>
		flt_ff == FLT_SINC2) else $error("filter did not step");
	cov_cal_both: cover property (wr && idx == IDX_CMD &&
		pwdata[7:0] == CMD_SELF_BOTH ##1 cal_active);
	cov_diode: cover property (diode_route);
	cov_sinc3: cover property (flt_ff == FLT_SINC3);
endmodule // ccc_core
`default_nettype wire

// ==== dv/ccc_host.sv ====
// host model: apb master and buffer-enable pin for the converter core
// assumes one pclk domain; the bench calls the tasks
`default_nettype none
module ccc_host (
	input  wire logic                        pclk,
	output logic                             psel,
	output logic                             penable,
	output logic                             pwrite,
	output logic [ccc_pkg::ADDR_W-1:0]       paddr,
	output logic [31:0]                      pwdata,
	input  wire logic [31:0]                 prdata,
	input  wire logic                        pready,
	input  wire logic                        pslverr,
	output logic                             buffer_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	import ccc_pkg::*;
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		buffer_pin = 1'b0;
	end
	//////////////////////////////////////////////////////////////////////
	// request held until pready is seen high at a rising edge, or 16 edges pass
	task automatic xfer(input logic wr, input logic [7:0] idx,
		input logic [7:0] wd, output logic [31:0] rd, output logic er,
		output logic to);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		to = 1'b1;
		n = 0;
		while (to && n < 16)
		begin
			@(posedge pclk);
			n++;
			to = (pready !== 1'b1);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released data lines must not show a stale value
		pwdata <= ~pwdata;
	endtask
	task automatic set_pin(input logic v);
		@(posedge pclk);
		buffer_pin <= v;
	endtask
	// pin kept low in case the reference sits near the supply
	task automatic cal(input logic [7:0] code, output logic er,
		output logic to);
		logic [31:0] rd;
		set_pin(1'b0);
		xfer(1'b1, IDX_CMD, code, rd, er, to);
	endtask
endmodule // ccc_host
`default_nettype wire

// ==== dv/converter_config_calibration_tb.sv ====
// self-checking bench for the converter configuration core
// assumes the host model drives apb and the buffer pin
`default_nettype none
module converter_config_calibration_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ccc_pkg::*;
	localparam int DEC = 2;
	localparam int PER = 128 * DEC;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        buffer_pin, diode_route, buf_active, offset_sign;
	logic        modulator_clock, ref_on, reference_level_select;
	logic        cal_active, result_ready_n;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0]  chan_pos_en, chan_neg_en, burnout_src, burnout_sink;
	logic [7:0]  current_source_one, current_source_two, gain_sel;
	logic [2:0]  current_source_one_scale, current_source_two_scale;
	logic [6:0]  offset_mag;
	logic [1:0]  filter_active;
	int          err_total, cmp_count;
	ccc_core #(.DECIM(DEC)) dut_u (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .buffer_pin,
		.chan_pos_en, .chan_neg_en, .diode_route, .burnout_src,
		.burnout_sink, .buf_active, .current_source_one,
		.current_source_two, .current_source_one_scale, .current_source_two_scale, .gain_sel,
		.offset_sign, .offset_mag, .modulator_clock, .ref_on,
		.reference_level_select, .filter_active, .cal_active,
		.result_ready_n);
	ccc_host host_u (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .buffer_pin);
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	//////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("comparisons %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		cmp_count++;
		if (got !== ex)
		begin
			err_total++;
			$display("Error %s expected %0h seen %0h", nm, ex, got);
		end
	endtask
	task automatic chk_in(input string nm, input int lo, input int hi,
		input int got);
		cmp_count++;
		if (got < lo || got > hi)
		begin
			err_total++;
			$display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask
	task automatic tmo(input string nm);
		err_total++;
		$display("Error wait on %s expected end seen timeout", nm);
		end_sim();
	endtask
	task automatic rd(input logic [7:0] idx, output logic [31:0] r,
		output logic e);
		logic t;
		host_u.xfer(1'b0, idx, 8'h00, r, e, t);
		if (t) tmo("pready");
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic e, t;
		host_u.xfer(1'b1, idx, d, r, e, t);
		if (t) tmo("pready");
		chk("pslverr", 0, e);
		repeat (2) @(negedge pclk);
	endtask
	// counts negedges until sig reaches lvl, bounded
	task automatic wait_lvl(ref logic sig, input logic lvl, input int lim,
		input string nm, output int n);
		n = 0;
		while (sig !== lvl && n < lim)
		begin
			@(negedge pclk);
			n++;
		end
		if (n >= lim) tmo(nm);
	endtask
	function automatic logic [2:0] scl(input logic [1:0] r);
		return (r == 2'h0) ? 3'h0 : 3'h1 << (r - 2'h1);
	endfunction
	//////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("pos rst", 8'h01, chan_pos_en);
		chk("neg rst", 8'h02, chan_neg_en);
		chk("gain rst", 8'h01, gain_sel);
		chk("ready rst", 1, result_ready_n);
		chk("filter rst", FLT_FAST, filter_active);
	endtask
	task automatic t_mux();
		logic [2:0] n;
		logic [31:0] r;
		logic e;
		wr(IDX_ACR, 8'h80);
		for (int p = 0; p < 8; p++)
		begin
			n = 3'(p + 3);
			wr(IDX_MUX, {1'b0, 3'(p), 1'b0, n});
			chk("pos", 32'h1 << p, chan_pos_en);
			chk("neg", 32'h1 << n, chan_neg_en);
			chk("bo src", 32'h1 << p, burnout_src);
			chk("bo sink", 32'h1 << n, burnout_sink);
		end
		rd(IDX_MUX, r, e);
		chk("mux read", 32'h72, r);
		wr(IDX_ACR, 8'h00);
		chk("bo off", 0, burnout_src);
		wr(IDX_MUX, MUX_DIODE);
		chk("diode", 1, diode_route);
		chk("pos open", 0, chan_pos_en);
		chk("neg open", 0, chan_neg_en);
		chk("diode bias", 3'h1, current_source_one_scale);
		wr(IDX_MUX, 8'h01);
		chk("diode off", 0, diode_route);
	endtask
	task automatic t_acr();
		logic [2:0] g;
		for (int i = 0; i < 8; i++)
		begin
			g = 3'(i);
			wr(IDX_ACR, {1'b0, ~g[1:0], g[1:0], g});
			chk("gain", 32'h1 << i, gain_sel);
			chk("scale1", scl(g[1:0]), current_source_one_scale);
			chk("scale2", scl(~g[1:0]), current_source_two_scale);
		end
		wr(IDX_CURRENT_SOURCE_ONE, 8'hA5);
		wr(IDX_CURRENT_SOURCE_TWO, 8'h5A);
		chk("code1", 8'hA5, current_source_one);
		chk("code2", 8'h5A, current_source_two);
		wr(IDX_OFFSET_TRIM_CODE, 8'hC3);
		chk("sign", 1, offset_sign);
		chk("mag", 7'h43, offset_mag);
		wr(IDX_OFFSET_TRIM_CODE, 8'h3F);
		chk("sign", 0, offset_sign);
		chk("mag", 7'h3F, offset_mag);
	endtask
	task automatic t_setup();
		logic [3:0] v;
		for (int i = 0; i < 16; i++)
		begin
			v = 4'(i);
			host_u.set_pin(v[3]);
			wr(IDX_SETUP, {4'h0, v[2:0], 1'b0});
			repeat (3) @(negedge pclk);
			chk("ref on", v[2], ref_on);
			chk("ref lvl", v[1], reference_level_select);
			chk("buffer", v[0] & v[3], buf_active);
		end
	endtask
	task automatic t_mod();
		int n, c;
		for (int s = 0; s < 2; s++)
		begin
			wr(IDX_SETUP, 8'(s << SETUP_SPEED));
			c = 0;
			for (int k = 0; k < 4; k++)
			begin
				wait_lvl(modulator_clock, k[0], 600, "modulator_clock", n);
				if (k >= 2) c += n;
			end
			chk_in("mod period", 128 << s, 128 << s, c);
		end
		wr(IDX_SETUP, 8'h02);
	endtask
	task automatic t_cal();
		int n, k;
		logic e, t;
		for (int c = 1; c < 7; c++)
		begin
			k = (8'(c) == CMD_SELF_BOTH) ? 14 : 7;
			wr(IDX_ACR, 8'(c));
			host_u.cal(8'(c), e, t);
			if (t) tmo("pready");
			repeat (2) @(negedge pclk);
			chk("cal busy", c < 6, cal_active);
			if (c < 6) chk("ready busy", 1, result_ready_n);
			chk("buf in cal", 0, buf_active);
			wait_lvl(cal_active, 1'b0, 5000, "cal_active", n);
			if (c < 6) chk("ready done", 0, result_ready_n);
			if (c < 6) chk_in("cal len", k*PER-PER, k*PER+4, n+2);
		end
	endtask
	task automatic t_ready();
		int n;
		logic [31:0] r;
		logic e;
		wait_lvl(result_ready_n, 1'b0, PER + 8, "ready", n);
		rd(IDX_DATA, r, e);
		@(negedge pclk);
		chk("ready read", 1, result_ready_n);
		wait_lvl(result_ready_n, 1'b0, PER + 8, "ready", n);
		chk_in("ready next", 1, PER + 4, n);
	endtask
	task automatic t_filter();
		int n;
		for (int m = 1; m < 4; m++)
		begin
			wr(IDX_MDEC1, 8'(m << MDEC1_SMODE));
			chk("filter", m, filter_active);
		end
		wr(IDX_MDEC1, {3'h0, SMODE_AUTO, 3'h0});
		wr(IDX_MUX, 8'h23);
		chk("auto fast", FLT_FAST, filter_active);
		for (int f = 2; f < 4; f++)
		begin
			n = 0;
			while (filter_active === 2'(f - 1) && n < 3 * PER)
			begin
				@(negedge pclk);
				n++;
			end
			chk("auto step", f, filter_active);
		end
		wr(IDX_ACR, 8'h05);
		chk("gain fast", FLT_FAST, filter_active);
	endtask
	task automatic t_bad();
		logic [31:0] r;
		logic e;
		rd(8'h3F, r, e);
		chk("bad err", 1, e);
		chk("bad data", 0, r);
	endtask
	initial
	begin
		err_total = 0;
		cmp_count = 0;
		presetn = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(negedge pclk);
		t_reset();
		t_mux();
		t_acr();
		t_setup();
		t_mod();
		t_cal();
		t_ready();
		t_filter();
		t_bad();
		end_sim();
	end
endmodule // converter_config_calibration_tb
`default_nettype wire
